// [hw/cmd_pkg.sv]
// Shared constants for the host command link: command and status codes,
// field offsets, flush values and injection modes.
// Assumes little-endian codes and lengths on a byte-wide stream.
package cmd_pkg;
  localparam logic [15:0] CMD_BOOT_FLASH   = 16'h0006;
  localparam logic [15:0] CMD_INJECT_MODE  = 16'h0007;
  localparam logic [15:0] CMD_INJECT_DATA  = 16'h0008;
  localparam logic [15:0] CMD_FIFO_FLUSH   = 16'h0009;
  localparam logic [15:0] STS_INJ_CFG_REQ  = 16'h0004;
  localparam logic [15:0] LEN_BOOT_FLASH   = 16'h0000;
  localparam logic [15:0] LEN_INJECT_MODE  = 16'h0004;
  localparam logic [15:0] LEN_FIFO_FLUSH   = 16'h0004;
  localparam logic [15:0] LEN_INJ_CFG_REQ  = 16'h0008;
  localparam logic [15:0] LEN_INJECT_MAX   = 16'h007C;
  localparam logic [7:0]  OFS_PAYLOAD      = 8'h04;
  localparam logic [7:0]  OFS_SENSOR_ID    = 8'h08;
  localparam logic [7:0]  OFS_CFG_END      = 8'h0B;
  localparam logic [1:0]  WORD_ALIGN_MASK  = 2'h3;
  localparam logic [7:0]  MODE_NORMAL      = 8'h00;
  localparam logic [7:0]  MODE_REALTIME    = 8'h01;
  localparam logic [7:0]  MODE_STEP        = 8'h02;
  localparam logic [7:0]  FL_SEND_ALL      = 8'hFF;
  localparam logic [7:0]  FL_DROP_ALL      = 8'hFE;
  localparam logic [7:0]  FL_SEND_WAKE     = 8'hFD;
  localparam logic [7:0]  FL_SEND_NWAKE    = 8'hFC;
  localparam logic [7:0]  FL_DROP_WAKE     = 8'hFB;
  localparam logic [7:0]  FL_DROP_NWAKE    = 8'hFA;
  localparam logic [7:0]  FL_DROP_DEBUG    = 8'hF9;
endpackage

// [hw/cmd_link_if.sv]
// Byte-wide link between the host end and the device's command port.
// Two streams: commands host to device, status bytes device to host.
`timescale 1ns/1ps
interface cmd_link_if;
  logic [7:0] cmd_data;
  logic       cmd_valid;
  logic       cmd_ready;
  logic [7:0] sts_data;
  logic       sts_valid;
  logic       sts_ready;
  logic       host_irq_out;
  modport dev (input cmd_data, cmd_valid, sts_ready, output cmd_ready, sts_data, sts_valid, host_irq_out);
  modport host (output cmd_data, cmd_valid, sts_ready, input cmd_ready, sts_data, sts_valid, host_irq_out);
endinterface

// [hw/cmd_device.sv]
// Device end: parses command packets, keeps boot, injection and flush state,
// and sends injected sensor configuration requests as status packets.
// Assumes the host keeps to whole 4-byte words and valid length fields.
`timescale 1ns/1ps
module cmd_device import cmd_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Reset cause and straps
  input  wire logic        host_port_reset,
  input  wire logic        host_boot_strap,
  input  wire logic        image_valid,
  // Link
  cmd_link_if.dev          link,
  // Sensor configuration request from the fusion core
  input  wire logic        cfg_req_valid,
  input  wire logic [31:0] cfg_req_rate,
  input  wire logic [7:0]  cfg_req_sensor,
  output logic             cfg_req_ready,
  // FIFO side
  input  wire logic        wake_avail,
  input  wire logic        nwake_avail,
  input  wire logic        fifo_irq_cond,
  output logic             boot_flash_go,
  output logic [1:0]       inject_mode,
  output logic [1:0]       send_fifo,
  output logic [2:0]       drop_fifo,
  output logic [1:0]       flush_done_evt,
  output logic             xfer_cancel,
  output logic             inject_valid,
  output logic [7:0]       inject_byte,
  input  wire logic        inject_ready
);
  typedef enum logic [1:0] {P_CODE = 2'b00, P_LEN = 2'b01, P_BODY = 2'b11} parse_e;
  parse_e      st_q;
  logic [15:0] code_q;
  logic [15:0] len_q;
  logic [15:0] cnt_q;
  logic        hp_sync1_q, hp_sync2_q, strap_s1_q, strap_s2_q;
  logic [1:0]  settle_q;
  logic        boot_armed_q;
  logic        send_pend_q;
  logic [7:0]  cfg_buf_q [0:11];
  logic [3:0]  tx_idx_q;
  logic        tx_busy_q;
  logic        cmd_ready_q;

  wire take = link.cmd_valid && cmd_ready_q;
  wire last = (st_q == P_BODY) ? (cnt_q + 16'h1 == len_q) : 1'b0;
  wire done = take && ((st_q == P_LEN && cnt_q[0] && {link.cmd_data, len_q[7:0]} == 16'h0) || last);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hp_sync1_q <= 1'b0;
      hp_sync2_q <= 1'b0;
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      settle_q   <= 2'b00;
    end else begin
      settle_q   <= {settle_q[0], 1'b1};
      hp_sync1_q <= host_port_reset;
      hp_sync2_q <= hp_sync1_q;
      strap_s1_q <= host_boot_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Packet framing; inject data payload is back-pressured by the consumer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= P_CODE;
      code_q <= 16'h0;
      len_q  <= 16'h0;
      cnt_q  <= 16'h0;
    end else if (take) begin
      case (st_q)
        P_CODE: begin
          if (cnt_q[0]) code_q[15:8] <= link.cmd_data;
          else code_q[7:0] <= link.cmd_data;
          cnt_q <= cnt_q[0] ? 16'h0 : 16'h1;
          if (cnt_q[0]) st_q <= P_LEN;
        end
        P_LEN: begin
          if (cnt_q[0]) len_q[15:8] <= link.cmd_data;
          else len_q[7:0] <= link.cmd_data;
          cnt_q <= cnt_q[0] ? 16'h0 : 16'h1;
          if (cnt_q[0]) st_q <= ({link.cmd_data, len_q[7:0]} == 16'h0) ? P_CODE : P_BODY;
        end
        P_BODY: begin
          cnt_q <= last ? 16'h0 : cnt_q + 16'h1;
          if (last) st_q <= P_CODE;
        end
        default: st_q <= P_CODE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cmd_ready_q <= 1'b0;
    else cmd_ready_q <= !(st_q == P_BODY && code_q == CMD_INJECT_DATA && !inject_ready);
  end
  assign link.cmd_ready = cmd_ready_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inject_valid <= 1'b0;
      inject_byte  <= 8'h00;
    end else begin
      inject_valid <= take && st_q == P_BODY && code_q == CMD_INJECT_DATA && inject_mode != 2'd0;
      inject_byte  <= link.cmd_data;
    end
  end

  // Boot: decided only once cause and strap have crossed the synchronisers;
  // the cause is read once, so a lasting cause level cannot block the command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_armed_q  <= 1'b1;
      boot_flash_go <= 1'b0;
    end else begin
      boot_flash_go <= 1'b0;
      if (boot_armed_q) begin
        if (settle_q[1]) begin
          boot_armed_q  <= 1'b0;
          boot_flash_go <= !hp_sync2_q && !strap_s2_q && image_valid;
        end
      end else if (done && code_q == CMD_BOOT_FLASH && st_q == P_LEN)
        boot_flash_go <= !strap_s2_q && image_valid;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) inject_mode <= 2'd0;
    else if (take && st_q == P_BODY && code_q == CMD_INJECT_MODE && cnt_q == 16'h0 &&
             link.cmd_data <= MODE_STEP) inject_mode <= link.cmd_data[1:0];
  end

  // Flush decode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      send_fifo      <= 2'b00;
      drop_fifo      <= 3'b000;
      flush_done_evt <= 2'b00;
      xfer_cancel    <= 1'b0;
      send_pend_q    <= 1'b0;
    end else begin
      send_fifo      <= 2'b00;
      drop_fifo      <= 3'b000;
      flush_done_evt <= 2'b00;
      xfer_cancel    <= 1'b0;
      if (take && st_q == P_BODY && code_q == CMD_FIFO_FLUSH && cnt_q == 16'h0) begin
        case (link.cmd_data)
          FL_SEND_ALL:   begin send_fifo <= 2'b11; flush_done_evt <= 2'b11; end
          FL_SEND_WAKE:  begin send_fifo <= 2'b01; flush_done_evt <= 2'b01; end
          FL_SEND_NWAKE: begin send_fifo <= 2'b10; flush_done_evt <= 2'b10; end
          FL_DROP_ALL:   begin drop_fifo <= 3'b111; xfer_cancel <= 1'b1; end
          FL_DROP_WAKE:  begin drop_fifo <= 3'b001; xfer_cancel <= 1'b1; end
          FL_DROP_NWAKE: begin drop_fifo <= 3'b010; xfer_cancel <= 1'b1; end
          FL_DROP_DEBUG: begin drop_fifo <= 3'b100; xfer_cancel <= 1'b1; end
          default: ;
        endcase
        if (link.cmd_data inside {FL_SEND_ALL, FL_SEND_WAKE, FL_SEND_NWAKE}) send_pend_q <= 1'b1;
      end else if (!wake_avail && !nwake_avail) send_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) link.host_irq_out <= 1'b0;
    else link.host_irq_out <= (send_pend_q && (wake_avail || nwake_avail)) || fifo_irq_cond;
  end

  // Status packet: 12 bytes buffered, so a host stall loses nothing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy_q     <= 1'b0;
      tx_idx_q      <= 4'h0;
      cfg_req_ready <= 1'b0;
      for (int i = 0; i < 12; i++) cfg_buf_q[i] <= 8'h00;
    end else begin
      cfg_req_ready <= 1'b0;
      if (!tx_busy_q && cfg_req_valid && !cfg_req_ready && inject_mode != 2'd0) begin
        cfg_buf_q[0]  <= STS_INJ_CFG_REQ[7:0];
        cfg_buf_q[1]  <= STS_INJ_CFG_REQ[15:8];
        cfg_buf_q[2]  <= LEN_INJ_CFG_REQ[7:0];
        cfg_buf_q[3]  <= LEN_INJ_CFG_REQ[15:8];
        for (int i = 0; i < 4; i++) cfg_buf_q[4 + i] <= cfg_req_rate[8 * i +: 8];
        cfg_buf_q[OFS_SENSOR_ID[3:0]] <= cfg_req_sensor;
        for (int i = 9; i < 12; i++) cfg_buf_q[i] <= 8'h00;
        tx_busy_q     <= 1'b1;
        tx_idx_q      <= 4'h0;
        cfg_req_ready <= 1'b1;
      end else if (tx_busy_q && link.sts_ready) begin
        tx_idx_q <= tx_idx_q + 4'h1;
        if (tx_idx_q == OFS_CFG_END[3:0]) tx_busy_q <= 1'b0;
      end
    end
  end
  // Each byte stays on the link until the host takes it
  assign link.sts_valid = tx_busy_q;
  assign link.sts_data  = cfg_buf_q[tx_idx_q];
endmodule // cmd_device

// [hw/cmd_host.sv]
// Host end: turns user requests into command packets and collects status.
// Assumes the device end sits on the other modport of the link.
`timescale 1ns/1ps
module cmd_host import cmd_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Link
  cmd_link_if.host         link,
  // User requests: one packet per pulse while idle
  input  wire logic        req_valid,
  input  wire logic [15:0] req_code,
  input  wire logic [7:0]  req_arg,
  output logic             req_ready,
  // Status bytes received
  output logic             sts_valid,
  output logic [7:0]       sts_byte,
  output logic             irq_seen
);
  logic [7:0] pkt_q [0:7];
  logic [3:0] idx_q;
  logic [3:0] len_q;
  logic       busy_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q    <= 1'b0;
      idx_q     <= 4'h0;
      len_q     <= 4'h0;
      req_ready <= 1'b0;
      for (int i = 0; i < 8; i++) pkt_q[i] <= 8'h00;
    end else begin
      req_ready <= !busy_q && !req_valid;
      if (!busy_q && req_valid && req_ready) begin
        pkt_q[0] <= req_code[7:0];
        pkt_q[1] <= req_code[15:8];
        pkt_q[2] <= (req_code == CMD_BOOT_FLASH) ? LEN_BOOT_FLASH[7:0] : LEN_FIFO_FLUSH[7:0];
        pkt_q[3] <= 8'h00;
        pkt_q[4] <= req_arg;
        for (int i = 5; i < 8; i++) pkt_q[i] <= 8'h00;
        len_q  <= (req_code == CMD_BOOT_FLASH) ? 4'd4 : 4'd8;
        idx_q  <= 4'h0;
        busy_q <= 1'b1;
      end else if (busy_q && link.cmd_ready) begin
        idx_q <= idx_q + 4'h1;
        if (idx_q + 4'h1 == len_q) busy_q <= 1'b0;
      end
    end
  end
  assign link.cmd_valid = busy_q;
  assign link.cmd_data  = pkt_q[idx_q[2:0]];
  assign link.sts_ready = 1'b1;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sts_valid <= 1'b0;
      sts_byte  <= 8'h00;
      irq_seen  <= 1'b0;
    end else begin
      sts_valid <= link.sts_valid;
      sts_byte  <= link.sts_data;
      irq_seen  <= link.host_irq_out;
    end
  end
endmodule // cmd_host

// [bench/link_properties.sv]
// Concurrent checks on the command stream between host end and device end.
// Assumes one instance beside the link interface, connected by name.
`timescale 1ns/1ps
module link_properties import cmd_pkg::*; (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Command stream
  input wire logic [7:0] cmd_data,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready
);
  logic [7:0]  pos_q;
  logic [15:0] code_q;
  logic [15:0] len_q;
  logic        take;
  logic        last;
  logic [15:0] len_in;
  assign take   = cmd_valid && cmd_ready;
  assign len_in = {cmd_data, len_q[7:0]};
  // Packet end is known only once the length MSB is in
  assign last   = (pos_q == 8'h03 && len_in == 16'h0000) || (pos_q > 8'h03 && {8'h00, pos_q} == len_q + 16'h0003);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) pos_q <= 8'h00;
    else if (take) pos_q <= last ? 8'h00 : pos_q + 8'h01;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_q <= 16'h0000;
      len_q  <= 16'h0000;
    end else if (take) begin
      if (pos_q == 8'h00) code_q[7:0] <= cmd_data;
      if (pos_q == 8'h01) code_q[15:8] <= cmd_data;
      if (pos_q == 8'h02) len_q[7:0] <= cmd_data;
      if (pos_q == 8'h03) len_q[15:8] <= cmd_data;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_stall; cmd_valid && !cmd_ready; endsequence
  sequence s_len_in(logic [15:0] c); take && pos_q == 8'h03 && code_q == c; endsequence
  a_valid_held: assert property (s_stall |=> cmd_valid) else $error("command valid dropped while stalled");
  a_data_held: assert property (s_stall |=> $stable(cmd_data)) else $error("command byte changed while stalled");
  a_code_known: assert property (take && pos_q == 8'h02 |-> code_q inside {[CMD_BOOT_FLASH:CMD_FIFO_FLUSH]})
    else $error("unknown command code");
  a_boot_len_zero: assert property (s_len_in(CMD_BOOT_FLASH) |-> len_in == LEN_BOOT_FLASH)
    else $error("boot command length not zero");
  a_mode_len_four: assert property (s_len_in(CMD_INJECT_MODE) |-> len_in == LEN_INJECT_MODE)
    else $error("mode command length wrong");
  a_flush_len_four: assert property (s_len_in(CMD_FIFO_FLUSH) |-> len_in == LEN_FIFO_FLUSH)
    else $error("flush command length wrong");
  a_inject_len_max: assert property (s_len_in(CMD_INJECT_DATA) |-> len_in <= LEN_INJECT_MAX && len_in[1:0] == 2'h0)
    else $error("inject length too long or unpadded");
  a_flush_val_ok: assert property (take && pos_q == 8'h04 && code_q == CMD_FIFO_FLUSH |-> cmd_data >= FL_DROP_DEBUG)
    else $error("flush value outside the table");
  a_pkt_words: assert property (take && last |-> pos_q[1:0] == 2'h3)
    else $error("packet not a whole number of words");
endmodule // link_properties

// [bench/tb_top.sv]
// Self-checking bench: host end and device end joined by the link interface.
// Assumes the host end sends one packet per accepted request.
`timescale 1ns/1ps
module tb_top import cmd_pkg::*;;
  logic clk = 1'b0, reset_n = 1'b0, hpr = 1'b0, strap = 1'b0, img = 1'b1;
  logic wake = 1'b0, nwake = 1'b0, cond = 1'b0, req_valid = 1'b0;
  logic [15:0] req_code = 16'h0000;
  logic [7:0]  req_arg = 8'h00, fv;
  logic boot_go, cancel, req_ready, boot_acc, cancel_acc;
  logic [1:0] imode, send, done, send_acc, done_acc, exp_mode;
  logic [2:0] drop, drop_acc;
  logic        cfg_valid = 1'b0, cfg_ready, h_sts_valid, inj_valid, irq_seen;
  logic [31:0] cfg_rate = 32'h00000000, r;
  logic [7:0]  cfg_sensor = 8'h00, h_sts_byte, inj_byte, s;
  logic [7:0]  inj_sum = 8'h00;
  logic [7:0]  sts_buf [0:15];
  int          sts_cnt = 0, inj_cnt = 0;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  always #5 clk = ~clk;
  cmd_link_if link ();
  cmd_device cmd_device_i (.clk(clk), .reset_n(reset_n), .host_port_reset(hpr), .host_boot_strap(strap),
    .image_valid(img), .link(link.dev), .cfg_req_valid(cfg_valid), .cfg_req_rate(cfg_rate),
    .cfg_req_sensor(cfg_sensor), .cfg_req_ready(cfg_ready), .wake_avail(wake), .nwake_avail(nwake),
    .fifo_irq_cond(cond), .boot_flash_go(boot_go), .inject_mode(imode), .send_fifo(send), .drop_fifo(drop),
    .flush_done_evt(done), .xfer_cancel(cancel), .inject_valid(inj_valid), .inject_byte(inj_byte),
    .inject_ready(1'b1));
  cmd_host cmd_host_i (.clk(clk), .reset_n(reset_n), .link(link.host), .req_valid(req_valid),
    .req_code(req_code), .req_arg(req_arg), .req_ready(req_ready), .sts_valid(h_sts_valid),
    .sts_byte(h_sts_byte), .irq_seen(irq_seen));
  link_properties link_properties_i (.clk(clk), .reset_n(reset_n), .cmd_data(link.cmd_data),
    .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready));
  // Pulses are one cycle wide, so they are gathered until the next clear
  always @(posedge clk) begin
    boot_acc <= boot_acc | boot_go;
    send_acc <= send_acc | send;
    drop_acc <= drop_acc | drop;
    done_acc <= done_acc | done;
    cancel_acc <= cancel_acc | cancel;
    if (h_sts_valid && sts_cnt < 16) begin
      sts_buf[sts_cnt] <= h_sts_byte;
      sts_cnt <= sts_cnt + 1;
    end
    if (inj_valid) begin
      inj_cnt <= inj_cnt + 1;
      inj_sum <= inj_sum ^ inj_byte;
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic clear_acc();
    #1;
    {boot_acc, send_acc, drop_acc, done_acc, cancel_acc} = '0;
    sts_cnt = 0;
    inj_cnt = 0;
    inj_sum = 8'h00;
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic send_req(input logic [15:0] code, input logic [7:0] arg);
    wait_idle();
    clear_acc();
    @(posedge clk);
    req_valid <= 1'b1;
    req_code <= code;
    req_arg <= arg;
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (2) @(posedge clk);
    wait_idle();
  endtask
  // Request held until the one-cycle ready pulse is seen or the 50-cycle wait runs out, then dropped
  task automatic cfg_request(input logic [31:0] rate, input logic [7:0] sensor);
    clear_acc();
    @(posedge clk);
    cfg_valid <= 1'b1;
    cfg_rate <= rate;
    cfg_sensor <= sensor;
    @(posedge clk);
    for (int j = 0; j < 50 && cfg_ready !== 1'b1; j++) @(posedge clk);
    cfg_valid <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  function automatic logic [7:0] exp_sts(input int k, input logic [31:0] rate, input logic [7:0] sensor);
    case (k)
      0: return STS_INJ_CFG_REQ[7:0];
      1: return STS_INJ_CFG_REQ[15:8];
      2: return LEN_INJ_CFG_REQ[7:0];
      3: return LEN_INJ_CFG_REQ[15:8];
      4, 5, 6, 7: return rate[8 * (k - 4) +: 8];
      8: return sensor;
      default: return 8'h00;
    endcase
  endfunction
  task automatic do_reset(input logic cause);
    @(posedge clk);
    hpr <= cause;
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    clear_acc();
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  function automatic logic [1:0] exp_send(input logic [7:0] v);
    return v == FL_SEND_ALL ? 2'h3 : v == FL_SEND_WAKE ? 2'h1 : v == FL_SEND_NWAKE ? 2'h2 : 2'h0;
  endfunction
  function automatic logic [2:0] exp_drop(input logic [7:0] v);
    return v == FL_DROP_ALL ? 3'h7 : v == FL_DROP_WAKE ? 3'h1 : v == FL_DROP_NWAKE ? 3'h2 :
           v == FL_DROP_DEBUG ? 3'h4 : 3'h0;
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    int i;
    logic [7:0] m;
    void'($urandom(32'h3a7f2f3e));
    do_reset(1'b0);
    check("auto boot", boot_acc, 8'h01);
    $display("test power-on boot done");
    exp_mode = 2'h0;
    for (i = 0; i < 12; i++) begin
      m = (i < 4) ? 8'(3 - i) : 8'($urandom_range(0, 3));
      send_req(CMD_INJECT_MODE, m);
      if (m <= MODE_STEP) exp_mode = m[1:0];
      check("inject mode", imode, exp_mode);
    end
    $display("test injection mode done");
    send_req(CMD_INJECT_MODE, MODE_REALTIME);
    for (i = 0; i < 4; i++) begin
      r = (i == 0) ? 32'h00000000 : $urandom;
      s = 8'($urandom);
      cfg_request(r, s);
      check("status count", 8'(sts_cnt), 8'h0C);
      for (int k = 0; k < 12; k++) check("status byte", sts_buf[k], exp_sts(k, r, s));
    end
    m = 8'($urandom);
    send_req(CMD_INJECT_DATA, m);
    check("inject count", 8'(inj_cnt), 8'h04);
    check("inject payload", inj_sum, m);
    send_req(CMD_INJECT_MODE, MODE_NORMAL);
    cfg_request(32'h3F800000, 8'h01);
    check("request refused", 8'(sts_cnt), 8'h00);
    send_req(CMD_INJECT_DATA, m);
    check("inject refused", 8'(inj_cnt), 8'h00);
    $display("test injection status done");
    for (i = 0; i < 15; i++) begin
      fv = (i < 7) ? 8'(8'hF9 + i) : 8'($urandom_range(249, 255));
      wake <= 1'($urandom);
      nwake <= 1'($urandom);
      send_req(CMD_FIFO_FLUSH, fv);
      check("send fifo", send_acc, exp_send(fv));
      check("drop fifo", drop_acc, exp_drop(fv));
      check("flush done", done_acc, exp_send(fv));
      check("cancel", cancel_acc, exp_drop(fv) != 3'h0);
    end
    wake <= 1'b1;
    send_req(CMD_FIFO_FLUSH, FL_SEND_ALL);
    check("irq after flush", link.host_irq_out, 8'h01);
    $display("test flush done");
    wake <= 1'b0;
    nwake <= 1'b0;
    cond <= 1'b1;
    repeat (4) @(posedge clk);
    check("irq on fifo condition", link.host_irq_out, 8'h01);
    check("irq seen by host", irq_seen, 8'h01);
    cond <= 1'b0;
    repeat (4) @(posedge clk);
    check("irq idle", link.host_irq_out, 8'h00);
    $display("test fifo interrupt done");
    for (i = 0; i < 4; i++) begin
      strap <= i[0];
      img <= i[1];
      send_req(CMD_BOOT_FLASH, 8'h00);
      check("boot command", boot_acc, !i[0] && i[1]);
    end
    strap <= 1'b0;
    img <= 1'b1;
    $display("test boot command done");
    do_reset(1'b1);
    check("no auto boot", boot_acc, 8'h00);
    send_req(CMD_BOOT_FLASH, 8'h00);
    check("boot after port reset", boot_acc, 8'h01);
    $display("test port reset done");
    final_report();
  end
endmodule // tb_top
